/* File: shared/tfcp_pkg.sv */
// shared constants for the tape formatter command port
package tfcp_pkg;
  localparam int unsigned CLK_FREQ_HZ      = 20_000_000;
  // least pulse width for rewind and unload, in nanoseconds
  localparam int unsigned PULSE_MIN_NS     = 1000;
  localparam int unsigned PULSE_MIN_CYC    =
    (PULSE_MIN_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  // command strobe width and line setup/hold around it, in cycles
  localparam int unsigned STROBE_CYC       = 4;
  localparam int unsigned SETUP_CYC        = 2;
  localparam int unsigned HOLD_CYC         = 2;
  // formatter busy time, rewinding time, and counter and bus widths
  localparam int unsigned EXEC_CYC         = 16;
  localparam int unsigned REWIND_CYC       = 64;
  localparam int unsigned CNT_W            = 8;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned XPORT_W          = 2;
  // command qualifier bit positions
  localparam int unsigned CMD_REV          = 0;
  localparam int unsigned CMD_WRT          = 1;
  localparam int unsigned CMD_WFM          = 2;
  localparam int unsigned CMD_ERASE        = 3;
  localparam int unsigned CMD_LGAP         = 4;
  localparam int unsigned CMD_SMC          = 5;
  localparam int unsigned CMD_W            = 6;
endpackage : tfcp_pkg

/* File: shared/tfcp_if.sv */
// cable between tape controller and formatter, low-true lines
`timescale 1ns/1ps
interface tfcp_if;
  // controller to formatter, each low-true
  logic                         formatter_select_n;
  logic [tfcp_pkg::XPORT_W-1:0] transport_select_n;
  logic                         command_strobe_n;
  logic                         reverse_direction_n;
  logic                         write_command_n;
  logic                         file_mark_write_n;
  logic                         erase_tape_n;
  logic                         long_gap_select_n;
  logic                         speed_change_n;
  logic                         rewind_request_n;
  logic                         offline_unload_n;
  logic [tfcp_pkg::DATA_W-1:0]  write_data_bus_n;
  logic                         write_parity_n;
  logic                         last_word_line_n;
  logic                         formatter_enable_level_n;
  // formatter to controller
  logic                         formatter_busy_n;
  logic                         rewinding_indication_n;

  modport ctrl (
    output formatter_select_n, transport_select_n, command_strobe_n,
    output reverse_direction_n, write_command_n, file_mark_write_n,
    output erase_tape_n, long_gap_select_n, speed_change_n,
    output rewind_request_n, offline_unload_n, write_data_bus_n,
    output write_parity_n, last_word_line_n, formatter_enable_level_n,
    input  formatter_busy_n, rewinding_indication_n
  );
  modport fmtr (
    input  formatter_select_n, transport_select_n, command_strobe_n,
    input  reverse_direction_n, write_command_n, file_mark_write_n,
    input  erase_tape_n, long_gap_select_n, speed_change_n,
    input  rewind_request_n, offline_unload_n, write_data_bus_n,
    input  write_parity_n, last_word_line_n, formatter_enable_level_n,
    output formatter_busy_n, rewinding_indication_n
  );
endinterface : tfcp_if

/* File: logic/tfcp_ctrl.sv */
// controller end: drives commands and write data onto the cable
// Function
// - select line picks formatter zero or one
// - two-bit field picks one of four transports
// - qualifiers captured at strobe trailing edge
// - direction line: deasserted forward, asserted reverse
// - erase plus write means dummy write
// - erase, write, file mark: dummy file mark
// - long-gap line selects long or normal gap
// - speed-change with strobe toggles speed mode
// - rewind pulse at least minimum width
// - rewinding indication held during whole rewind
// - unload line held at least minimum time
// - write data eight bits, parity, bit zero MSB
// - enable deasserted holds transport in reset
// - last-word marked with final data character
// - all lines low-true, idle reads deasserted; select and qualifier lines hold the last command while idle
// - busy rises on strobe until command completes
`timescale 1ns/1ps
module tfcp_ctrl #(
  parameter int unsigned STROBE_CYC = tfcp_pkg::STROBE_CYC,
  parameter int unsigned SETUP_CYC  = tfcp_pkg::SETUP_CYC,
  parameter int unsigned HOLD_CYC   = tfcp_pkg::HOLD_CYC
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // command request
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic                          cmd_formatter_select,
  input  wire logic [tfcp_pkg::XPORT_W-1:0]  cmd_transport_select,
  input  wire logic [tfcp_pkg::CMD_W-1:0]    cmd_bits,
  // rewind and unload requests, one-cycle pulses
  input  wire logic                          rewind_go,
  input  wire logic                          unload_go,
  // write data, level, sampled each cycle
  input  wire logic                          wr_valid,
  input  wire logic [tfcp_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                          wr_last,
  // formatter enable level
  input  wire logic                          enable,
  // status toward user
  output logic                               busy,
  output logic                               rewinding,
  // cable
  tfcp_if.ctrl                               cab
);
  typedef enum logic [1:0] {TFCP_IDLE, TFCP_SETUP, TFCP_STROBE, TFCP_HOLD}
    tfcp_state_e;

  tfcp_state_e                     st_r, st_nxt;
  logic [tfcp_pkg::CNT_W-1:0]      cnt_r, cnt_nxt;
  logic                            fsel_r, fsel_nxt;
  logic [tfcp_pkg::XPORT_W-1:0]    tsel_r, tsel_nxt;
  logic [tfcp_pkg::CMD_W-1:0]      cmd_r, cmd_nxt;
  logic                            strobe_r, strobe_nxt;
  logic                            ready_r, ready_nxt;
  logic [tfcp_pkg::CNT_W-1:0]      rew_cnt_r, rew_cnt_nxt;
  logic [tfcp_pkg::CNT_W-1:0]      ofl_cnt_r, ofl_cnt_nxt;
  logic [tfcp_pkg::DATA_W-1:0]     wd_r, wd_nxt;
  logic                            wp_r, wp_nxt;
  logic                            lw_r, lw_nxt;
  logic                            en_r, en_nxt;
  logic [1:0]                      busy_s_r, rwd_s_r;

  // command sequencing
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    fsel_nxt   = fsel_r;
    tsel_nxt   = tsel_r;
    cmd_nxt    = cmd_r;
    strobe_nxt = 1'b0;
    ready_nxt  = 1'b0;
    unique case (st_r)
      TFCP_IDLE: begin
        ready_nxt = 1'b1;
        if (cmd_valid && ready_r) begin
          fsel_nxt  = cmd_formatter_select;
          tsel_nxt  = cmd_transport_select;
          cmd_nxt   = cmd_bits;
          ready_nxt = 1'b0;
          cnt_nxt   = '0;
          st_nxt    = TFCP_SETUP;
        end
      end
      TFCP_SETUP: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == tfcp_pkg::CNT_W'(SETUP_CYC - 1)) begin
          cnt_nxt    = '0;
          strobe_nxt = 1'b1;
          st_nxt     = TFCP_STROBE;
        end
      end
      TFCP_STROBE: begin
        strobe_nxt = 1'b1;
        cnt_nxt    = cnt_r + 1'b1;
        if (cnt_r == tfcp_pkg::CNT_W'(STROBE_CYC - 1)) begin
          cnt_nxt    = '0;
          strobe_nxt = 1'b0;
          st_nxt     = TFCP_HOLD;
        end
      end
      TFCP_HOLD: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == tfcp_pkg::CNT_W'(HOLD_CYC - 1)) begin
          cnt_nxt   = '0;
          ready_nxt = 1'b1;
          st_nxt    = TFCP_IDLE;
        end
      end
    endcase
  end

  // rewind, unload, write data and enable
  always_comb begin
    rew_cnt_nxt = rew_cnt_r;
    ofl_cnt_nxt = ofl_cnt_r;
    if (rewind_go && rew_cnt_r == '0)
      rew_cnt_nxt = tfcp_pkg::CNT_W'(tfcp_pkg::PULSE_MIN_CYC);
    else if (rew_cnt_r != '0)
      rew_cnt_nxt = rew_cnt_r - 1'b1;
    if (unload_go && ofl_cnt_r == '0)
      ofl_cnt_nxt = tfcp_pkg::CNT_W'(tfcp_pkg::PULSE_MIN_CYC);
    else if (ofl_cnt_r != '0)
      ofl_cnt_nxt = ofl_cnt_r - 1'b1;
    wd_nxt = {<<{wr_data}};
    if (!wr_valid)
      wd_nxt = '0;
    wp_nxt = wr_valid ? ~(^wr_data) : 1'b0;
    lw_nxt = wr_valid & wr_last;
    en_nxt = enable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r      <= TFCP_IDLE;
      cnt_r     <= '0;
      fsel_r    <= 1'b0;
      tsel_r    <= '0;
      cmd_r     <= '0;
      strobe_r  <= 1'b0;
      ready_r   <= 1'b0;
      rew_cnt_r <= '0;
      ofl_cnt_r <= '0;
      wd_r      <= '0;
      wp_r      <= 1'b0;
      lw_r      <= 1'b0;
      en_r      <= 1'b0;
      busy_s_r  <= 2'b00;
      rwd_s_r   <= 2'b00;
      busy      <= 1'b0;
      rewinding <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      fsel_r    <= fsel_nxt;
      tsel_r    <= tsel_nxt;
      cmd_r     <= cmd_nxt;
      strobe_r  <= strobe_nxt;
      ready_r   <= ready_nxt;
      rew_cnt_r <= rew_cnt_nxt;
      ofl_cnt_r <= ofl_cnt_nxt;
      wd_r      <= wd_nxt;
      wp_r      <= wp_nxt;
      lw_r      <= lw_nxt;
      en_r      <= en_nxt;
      busy_s_r  <= {busy_s_r[0], ~cab.formatter_busy_n};
      rwd_s_r   <= {rwd_s_r[0], ~cab.rewinding_indication_n};
      busy      <= busy_s_r[1];
      rewinding <= rwd_s_r[1];
    end
  end

  assign cmd_ready = ready_r;

  assign cab.formatter_select_n       = ~fsel_r;
  assign cab.transport_select_n       = ~tsel_r;
  assign cab.command_strobe_n         = ~strobe_r;
  assign cab.reverse_direction_n      = ~cmd_r[tfcp_pkg::CMD_REV];
  assign cab.write_command_n          = ~cmd_r[tfcp_pkg::CMD_WRT];
  assign cab.file_mark_write_n        = ~cmd_r[tfcp_pkg::CMD_WFM];
  assign cab.erase_tape_n             = ~cmd_r[tfcp_pkg::CMD_ERASE];
  assign cab.long_gap_select_n        = ~cmd_r[tfcp_pkg::CMD_LGAP];
  assign cab.speed_change_n           = ~cmd_r[tfcp_pkg::CMD_SMC];
  assign cab.rewind_request_n         = ~(rew_cnt_r != '0);
  assign cab.offline_unload_n         = ~(ofl_cnt_r != '0);
  assign cab.write_data_bus_n         = ~wd_r;
  assign cab.write_parity_n           = ~wp_r;
  assign cab.last_word_line_n         = ~lw_r;
  assign cab.formatter_enable_level_n = ~en_r;
endmodule : tfcp_ctrl

/* File: logic/tfcp_fmtr.sv */
// formatter end: captures commands and reports busy and rewinding
`timescale 1ns/1ps
module tfcp_fmtr #(
  parameter int unsigned EXEC_CYC   = tfcp_pkg::EXEC_CYC,
  parameter int unsigned REWIND_CYC = tfcp_pkg::REWIND_CYC
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // strap address of this formatter
  input  wire logic                          strap_addr,
  // captured command, one-cycle pulse with fields
  output logic                               cmd_pulse,
  output logic [tfcp_pkg::XPORT_W-1:0]       cmd_transport,
  output logic                               cmd_reverse,
  output logic                               cmd_write,
  output logic                               cmd_dummy_write,
  output logic                               cmd_dummy_mark,
  output logic                               cmd_file_mark,
  output logic                               cmd_space,
  output logic                               cmd_long_gap,
  // transport state
  output logic                               high_speed,
  output logic                               unload_pulse,
  output logic                               in_reset,
  // write data stream
  output logic                               wr_valid,
  output logic [tfcp_pkg::DATA_W-1:0]        wr_data,
  output logic                               wr_parity,
  output logic                               wr_last,
  // cable
  tfcp_if.fmtr                               cab
);
  localparam int unsigned LN = 14;
  logic [LN-1:0]                 s1_r, s2_r;
  logic [tfcp_pkg::DATA_W-1:0]   d1_r, d2_r;
  logic                          go_d_r;
  logic                          lw1_r, lw2_r;
  logic [tfcp_pkg::CNT_W-1:0]    ex_r, ex_nxt, rw_r, rw_nxt;
  logic [tfcp_pkg::CNT_W-1:0]    rq_w_r, rq_w_nxt, ul_w_r, ul_w_nxt;
  logic                          spd_r, spd_nxt;
  logic                          me, go, rq, ul, en, rq_ok, ul_ok;

  // two-flop synchronisers on low-true cable lines, inverted to true
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      d1_r <= '0;
      d2_r <= '0;
      lw1_r <= 1'b0;
      lw2_r <= 1'b0;
    end else begin
      s1_r <= ~{cab.formatter_select_n, cab.transport_select_n,
                cab.command_strobe_n, cab.reverse_direction_n,
                cab.write_command_n, cab.file_mark_write_n,
                cab.erase_tape_n, cab.long_gap_select_n,
                cab.speed_change_n, cab.rewind_request_n,
                cab.offline_unload_n, cab.write_parity_n,
                cab.formatter_enable_level_n};
      s2_r <= s1_r;
      d1_r <= ~cab.write_data_bus_n;
      d2_r <= d1_r;
      lw1_r <= ~cab.last_word_line_n;
      lw2_r <= lw1_r;
    end
  end

  assign me = (s2_r[13] == strap_addr);
  assign go = s2_r[10];
  assign rq = s2_r[3];
  assign ul = s2_r[2];
  assign en = s2_r[0];
  assign rq_ok = (rq_w_r == tfcp_pkg::CNT_W'(tfcp_pkg::PULSE_MIN_CYC - 1));
  assign ul_ok = (ul_w_r == tfcp_pkg::CNT_W'(tfcp_pkg::PULSE_MIN_CYC - 1));

  always_comb begin
    ex_nxt   = (ex_r != '0) ? ex_r - 1'b1 : ex_r;
    rw_nxt   = (rw_r != '0) ? rw_r - 1'b1 : rw_r;
    rq_w_nxt = (rq && !rq_ok) ? rq_w_r + 1'b1 : (rq ? rq_w_r : '0);
    ul_w_nxt = (ul && !ul_ok) ? ul_w_r + 1'b1 : (ul ? ul_w_r : '0);
    spd_nxt  = spd_r;
    if (go_d_r && !go && me) begin
      ex_nxt = tfcp_pkg::CNT_W'(EXEC_CYC);
      if (s2_r[4])
        spd_nxt = ~spd_r;
    end
    if (me && ((rq && rq_w_r == tfcp_pkg::CNT_W'(tfcp_pkg::PULSE_MIN_CYC - 2))
        || (ul && ul_w_r == tfcp_pkg::CNT_W'(tfcp_pkg::PULSE_MIN_CYC - 2))))
      rw_nxt = tfcp_pkg::CNT_W'(REWIND_CYC);
    if (!en) begin
      ex_nxt  = '0;
      rw_nxt  = '0;
      spd_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      go_d_r <= 1'b0;
      ex_r   <= '0;
      rw_r   <= '0;
      rq_w_r <= '0;
      ul_w_r <= '0;
      spd_r  <= 1'b0;
      cmd_pulse <= 1'b0;
      cmd_transport <= '0;
      {cmd_reverse, cmd_write, cmd_dummy_write, cmd_dummy_mark} <= '0;
      {cmd_file_mark, cmd_space, cmd_long_gap} <= '0;
      high_speed <= 1'b0;
      unload_pulse <= 1'b0;
      in_reset <= 1'b1;
      {wr_valid, wr_parity, wr_last} <= '0;
      wr_data <= '0;
    end else begin
      go_d_r <= go;
      ex_r   <= ex_nxt;
      rw_r   <= rw_nxt;
      rq_w_r <= rq_w_nxt;
      ul_w_r <= ul_w_nxt;
      spd_r  <= spd_nxt;
      cmd_pulse     <= go_d_r && !go && me && en;
      cmd_transport <= s2_r[12:11];
      cmd_reverse   <= s2_r[9];
      cmd_write     <= s2_r[8] && !s2_r[6];
      cmd_dummy_write <= s2_r[6] && s2_r[8] && !s2_r[7];
      cmd_dummy_mark  <= s2_r[6] && s2_r[8] && s2_r[7];
      cmd_file_mark   <= s2_r[8] && s2_r[7] && !s2_r[6];
      cmd_space       <= s2_r[6] && !s2_r[8];
      cmd_long_gap    <= s2_r[5];
      high_speed   <= spd_r;
      unload_pulse <= me && en && ul && ul_w_r ==
                      tfcp_pkg::CNT_W'(tfcp_pkg::PULSE_MIN_CYC - 2);
      in_reset  <= !en;
      wr_valid  <= en && me;
      wr_data   <= {<<{d2_r}};
      wr_parity <= s2_r[1];
      wr_last   <= lw2_r;
    end
  end

  assign cab.formatter_busy_n       = ~(ex_r != '0);
  assign cab.rewinding_indication_n = ~(rw_r != '0);
endmodule : tfcp_fmtr

/* File: sim/tfcp_sva.sv */
// cable-level assertions for the tape formatter command port
`timescale 1ns/1ps
module tfcp_sva (
  // clock and reset
  input wire logic                         clk,
  input wire logic                         rst,
  // controller to formatter
  input wire logic                         formatter_select_n,
  input wire logic [tfcp_pkg::XPORT_W-1:0] transport_select_n,
  input wire logic                         command_strobe_n,
  input wire logic                         reverse_direction_n,
  input wire logic                         write_command_n,
  input wire logic                         file_mark_write_n,
  input wire logic                         erase_tape_n,
  input wire logic                         long_gap_select_n,
  input wire logic                         speed_change_n,
  input wire logic                         rewind_request_n,
  input wire logic                         offline_unload_n,
  input wire logic                         formatter_enable_level_n,
  // formatter to controller
  input wire logic                         formatter_busy_n,
  input wire logic                         rewinding_indication_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] go_r, go_nxt, by_r, by_nxt, rw_r, rw_nxt;
  logic [7:0] ul_r, ul_nxt, rq_r, rq_nxt;
  logic [8:0] qual;
  assign qual = {formatter_select_n, transport_select_n, reverse_direction_n,
                 write_command_n, file_mark_write_n, erase_tape_n,
                 long_gap_select_n, speed_change_n};
  function automatic logic [7:0] sat(input logic [7:0] v, input logic clr);
    return clr ? 8'h00 : ((v == 8'hff) ? v : v + 8'h01);
  endfunction : sat
  always_comb begin
    go_nxt = sat(go_r, !command_strobe_n);
    by_nxt = sat(by_r, formatter_busy_n);
    rw_nxt = sat(rw_r, rewind_request_n);
    ul_nxt = sat(ul_r, offline_unload_n);
    rq_nxt = sat(rq_r, !rewind_request_n || !offline_unload_n);
  end
  always_ff @(posedge clk) begin
    go_r <= rst ? 8'hff : go_nxt;
    by_r <= rst ? 8'h00 : by_nxt;
    rw_r <= rst ? 8'h00 : rw_nxt;
    ul_r <= rst ? 8'h00 : ul_nxt;
    rq_r <= rst ? 8'hff : rq_nxt;
  end
  strobe_width_a: assert property (
    $fell(command_strobe_n) |-> !command_strobe_n [*4] ##1 command_strobe_n)
    else $error("command strobe width wrong");
  qual_stable_a: assert property (
    (!command_strobe_n || $past(!command_strobe_n)) |-> $stable(qual))
    else $error("qualifier moved around strobe");
  busy_cause_a: assert property (
    $fell(formatter_busy_n) |-> go_r <= 8'h08)
    else $error("busy rose without strobe");
  busy_answer_a: assert property (
    $rose(command_strobe_n) && formatter_select_n && !formatter_enable_level_n
    |-> ##[1:8] !formatter_busy_n)
    else $error("busy missing after strobe");
  busy_length_a: assert property (
    $rose(formatter_busy_n) |-> by_r >= 8'h0f && by_r <= 8'h11)
    else $error("busy length wrong");
  rewind_width_a: assert property (
    $rose(rewind_request_n) |-> rw_r >= tfcp_pkg::PULSE_MIN_CYC)
    else $error("rewind pulse too short");
  unload_width_a: assert property (
    $rose(offline_unload_n) |-> ul_r >= tfcp_pkg::PULSE_MIN_CYC)
    else $error("unload pulse too short");
  rewind_no_busy_a: assert property (
    ($fell(rewind_request_n) || $fell(offline_unload_n)) && formatter_busy_n
    |-> formatter_busy_n [*8])
    else $error("busy raised by rewind");
  rewinding_cause_a: assert property (
    $fell(rewinding_indication_n) |-> rq_r <= 8'h08)
    else $error("rewinding without request");
  rewinding_hold_a: assert property (
    $fell(rewinding_indication_n) |-> !rewinding_indication_n [*8])
    else $error("rewinding dropped early");
  idle_lines_a: assert property (
    $past(rst) |-> command_strobe_n && rewind_request_n && offline_unload_n
    && formatter_enable_level_n)
    else $error("cable not idle after reset");
  cover property ($fell(command_strobe_n));
  cover property ($fell(rewind_request_n));
  cover property ($fell(offline_unload_n));
  cover property ($fell(formatter_busy_n));
endmodule : tfcp_sva

/* File: sim/tb.sv */
// self-checking bench for both ends of the tape formatter cable
`timescale 1ns/1ps
module tb;
  logic       clk, rst, cmd_valid, cmd_ready, cmd_fsel, rewind_go, unload_go;
  logic       wr_valid, wr_last, enable, busy, rewinding, hs;
  logic       f_pulse, f_rev, f_wr, f_dw, f_dm, f_fm, f_sp, f_lg, f_hs;
  logic       f_unl, f_rst, f_wv, f_wp, f_wl;
  logic [1:0] cmd_xport, f_xport;
  logic [5:0] cmd_bits;
  logic [7:0] wr_data, f_wd, lfsr;
  logic [8:0] cmd_q[$];
  logic [8:0] f_cmd;
  logic [8:0] wr_q[$];
  int         error_cnt, cmp_count;
  logic [5:0] tbl [12] = '{6'h00, 6'h01, 6'h02, 6'h06, 6'h08, 6'h09,
                           6'h0a, 6'h0e, 6'h12, 6'h20, 6'h21, 6'h3f};
  tfcp_if tfcp_if_inst ();
  assign f_cmd = {f_xport, f_rev, f_dw, f_dm, f_lg, f_wr, f_fm, f_sp};
  tfcp_ctrl tfcp_ctrl_inst (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_formatter_select(cmd_fsel),
    .cmd_transport_select(cmd_xport), .cmd_bits(cmd_bits),
    .rewind_go(rewind_go), .unload_go(unload_go), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_last(wr_last), .enable(enable), .busy(busy),
    .rewinding(rewinding), .cab(tfcp_if_inst));
  tfcp_fmtr tfcp_fmtr_inst (.clk(clk), .rst(rst), .strap_addr(1'b0),
    .cmd_pulse(f_pulse), .cmd_transport(f_xport), .cmd_reverse(f_rev),
    .cmd_write(f_wr), .cmd_dummy_write(f_dw), .cmd_dummy_mark(f_dm),
    .cmd_file_mark(f_fm), .cmd_space(f_sp), .cmd_long_gap(f_lg),
    .high_speed(f_hs), .unload_pulse(f_unl), .in_reset(f_rst),
    .wr_valid(f_wv), .wr_data(f_wd), .wr_parity(f_wp), .wr_last(f_wl),
    .cab(tfcp_if_inst));
  tfcp_sva tfcp_sva_inst (.clk(clk), .rst(rst),
    .formatter_select_n(tfcp_if_inst.formatter_select_n),
    .transport_select_n(tfcp_if_inst.transport_select_n),
    .command_strobe_n(tfcp_if_inst.command_strobe_n),
    .reverse_direction_n(tfcp_if_inst.reverse_direction_n),
    .write_command_n(tfcp_if_inst.write_command_n),
    .file_mark_write_n(tfcp_if_inst.file_mark_write_n),
    .erase_tape_n(tfcp_if_inst.erase_tape_n),
    .long_gap_select_n(tfcp_if_inst.long_gap_select_n),
    .speed_change_n(tfcp_if_inst.speed_change_n),
    .rewind_request_n(tfcp_if_inst.rewind_request_n),
    .offline_unload_n(tfcp_if_inst.offline_unload_n),
    .formatter_enable_level_n(tfcp_if_inst.formatter_enable_level_n),
    .formatter_busy_n(tfcp_if_inst.formatter_busy_n),
    .rewinding_indication_n(tfcp_if_inst.rewinding_indication_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    logic v;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      v = (sel == 0) ? busy : (sel == 3) ? cmd_ready : f_rst;
      if (v === lvl) return;
    end
    check(~lvl, lvl);
    report_and_stop();
  endtask : wait_sig
  task automatic send_cmd(input logic sel, input logic [5:0] bits);
    lfsr = lfsr_next(lfsr);
    @(negedge clk);
    cmd_fsel = sel;
    cmd_xport = lfsr[1:0];
    cmd_bits = bits;
    cmd_valid = 1'b1;
    if (!sel) cmd_q.push_back({lfsr[1:0], bits[0], bits[3] & bits[1] &
                               !bits[2], &bits[3:1], bits[4],
                               bits[1] & !bits[3],
                               bits[1] & bits[2] & !bits[3],
                               bits[3] & !bits[1]});
    for (int i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (cmd_ready !== 1'b1) begin
      check(cmd_ready, 1'b1);
      report_and_stop();
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    if (sel) begin
      repeat (40) @(posedge clk);
      check(busy, 1'b0);
    end else begin
      wait_sig(0, 1'b1, 40);
      check(busy, 1'b1);
      wait_sig(0, 1'b0, 80);
      hs = hs ^ bits[5];
      check(f_hs, hs);
    end
  endtask : send_cmd
  task automatic rew(input logic unl);
    logic seen_rw = 1'b0;
    logic seen_by = 1'b0;
    logic seen_ul = 1'b0;
    @(negedge clk);
    rewind_go = !unl;
    unload_go = unl;
    @(negedge clk);
    rewind_go = 1'b0;
    unload_go = 1'b0;
    for (int i = 0; i < 160; i++) begin
      @(posedge clk);
      #1;
      seen_rw = seen_rw | rewinding;
      seen_by = seen_by | busy;
      seen_ul = seen_ul | f_unl;
    end
    check(seen_rw, 1'b1);
    check(seen_by, 1'b0);
    check(seen_ul, unl);
    check(rewinding, 1'b0);
  endtask : rew
  task automatic stream(input int n);
    logic [7:0] prev;
    logic [7:0] r;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      r = {<<{prev}};
      if (i > 0) check({tfcp_if_inst.write_parity_n,
        tfcp_if_inst.last_word_line_n, tfcp_if_inst.write_data_bus_n},
        {^prev, i != n, ~r});
      lfsr = lfsr_next(lfsr);
      prev = lfsr;
      wr_valid = (i < n);
      wr_data = prev;
      wr_last = (i == n - 1);
      if (i < n) wr_q.push_back({wr_last, prev});
    end
  endtask : stream
  always @(negedge clk) begin
    if (f_pulse === 1'b1) begin
      check(cmd_q.size() != 0, 1'b1);
      if (cmd_q.size() != 0)
        check(f_cmd, cmd_q.pop_front());
    end
    if (f_wv === 1'b1 && f_wd !== 8'h00 && wr_q.size() != 0) begin
      check({f_wl, f_wd}, wr_q.pop_front());
      check(^{f_wd, f_wp}, 1'b1);
    end
  end
  initial begin
    {rst, cmd_valid, cmd_fsel, rewind_go, unload_go, wr_valid} = 6'h20;
    {wr_last, enable, hs, cmd_xport, cmd_bits, wr_data} = 19'h0_0000;
    lfsr = 8'h47;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check({tfcp_if_inst.command_strobe_n, tfcp_if_inst.rewind_request_n,
      tfcp_if_inst.offline_unload_n,
      tfcp_if_inst.formatter_enable_level_n}, 4'hf);
    check(f_rst, 1'b1);
    enable = 1'b1;
    wait_sig(4, 1'b0, 20);
    $display("test reset done");
    for (int k = 0; k < 12; k++) send_cmd(1'b0, tbl[k]);
    for (int k = 0; k < 4; k++)
      send_cmd(1'b0, 6'(lfsr_next(lfsr) & 8'h3b));
    rew(1'b0);
    rew(1'b1);
    $display("test rewind done");
    send_cmd(1'b1, 6'h01);
    $display("test commands done");
    send_cmd(1'b0, 6'h02);
    stream(6);
    repeat (5) @(posedge clk);
    $display("test write data done");
    enable = 1'b0;
    wait_sig(4, 1'b1, 20);
    check(cmd_q.size() + wr_q.size(), 0);
    $display("test enable done");
    report_and_stop();
  end
endmodule : tb
